// ---- hdl/ext_int_config.sv ----
/*
 * External interrupt configuration: two pin-selectable interrupt inputs with
 * polarity and trigger type, their pending flags, the second extended
 * priority register and the crossbar skip gating of port pin drive.
 * Assumes a classic Wishbone master, port pins synchronous to clk, and a CPU
 * that pulses vector_ack for one cycle when it vectors to a channel.
 */
// Our own choice: the Wishbone interface to the registers.
// Operation
// RL1 - Priority bits 7:4 read zero, writes ignored
// RL2 - Bit 3 sets radio serial priority
// RL3 - Bit 2 sets oscillator fail priority
// RL4 - Bit 1 sets port match priority
// RL5 - Bit 0 sets supply warning priority
// RL6 - Each input: polarity and edge/level independently
// RL7 - Trigger bit one is edge, zero level
// RL8 - Polarity bit one active high, zero low
// RL9 - Three-bit select picks port 0 pin
// RL10 - Inputs read pins without disturbing crossbar
// RL11 - Skipped pins are routed to no peripheral
// RL12 - Pending flags at control bits 1, 3
// RL13 - Edge sets flag; vectoring clears it
// RL14 - Level mode flag follows active input
// RL15 - Level source holds request until recognized
// RL16 - Level source drops request before return
// RL17 - Pin configuration resets to 0x01
// RL18 - Edge found from current and previous sample
module ext_int_config
  import eic_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [7:0]       port0_pins,
  input  wire logic [1:0]       vector_ack,
  input  wire logic [7:0]       crossbar_skip,
  input  wire logic [7:0]       periph_pin_out,
  input  wire logic [7:0]       periph_pin_oe,
  output logic [7:0]            pin_out,
  output logic [7:0]            pin_oe,
  output logic                  first_input_pending,
  output logic                  second_input_pending,
  output logic                  radio_serial_irq_priority,
  output logic                  rtc_osc_fail_priority,
  output logic                  port_match_priority,
  output logic                  supply_warning_priority
);
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [3:0] prio_reg;
  logic [3:0] prio_next;
  logic [1:0] trig_reg;
  logic [1:0] trig_next;
  logic       wr_commit;
  logic [7:0] rd_word;
  logic [1:0] pend;
  logic [1:0] rise;

  wire [ADR_W-1:0] word_adr = {wb_adr_i[ADR_W-1:2], 2'h0};
  wire             hit_cfg  = (word_adr == CFG_ADDR);
  wire             hit_prio = (word_adr == PRIO_ADDR);
  wire             hit_tctl = (word_adr == TCTL_ADDR);
  wire [7:0]       wbyte    = wb_dat_i[7:0];
  wire             wr_cfg   = wr_commit & hit_cfg;
  wire             wr_prio  = wr_commit & hit_prio;
  wire             wr_tctl  = wr_commit & hit_tctl;

  // Bus handshake and read data capture.
  wb_front u_front (
    .clk       (clk),
    .rst       (rst),
    .cyc       (wb_cyc_i),
    .stb       (wb_stb_i),
    .we        (wb_we_i),
    .sel0      (wb_sel_i[0]),
    .rd_word   (rd_word),
    .ack       (wb_ack_o),
    .dat_o     (wb_dat_o),
    .wr_commit (wr_commit)
  );

  // The timer control view holds only the trigger and pending bits of both
  // inputs; the timer bits of that register live in the timer block.
  wire [7:0] tctl_view = {4'h0, pend[1], trig_reg[1], pend[0], trig_reg[0]}; // RL12

  // Unmapped addresses still answer, reading zero and ignoring writes.
  assign rd_word = hit_cfg  ? cfg_reg :
                   hit_prio ? {PRIO_UNUSED, prio_reg} : // RL1
                   hit_tctl ? tctl_view : 8'h00;

  assign cfg_next  = wr_cfg  ? wbyte : cfg_reg;
  // Only the low nibble is stored, so upper written bits vanish.
  assign prio_next = wr_prio ? wbyte[3:0] : prio_reg; // RL1
  assign trig_next = wr_tctl ? {wbyte[SECOND_TRIG_BIT], wbyte[FIRST_TRIG_BIT]} : trig_reg; // RL7

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg  <= CFG_RESET; // RL17
      prio_reg <= PRIO_RESET;
      trig_reg <= TRIG_RESET;
    end else begin
      cfg_reg  <= cfg_next;
      prio_reg <= prio_next;
      trig_reg <= trig_next;
    end
  end

  assign radio_serial_irq_priority = prio_reg[RADIO_BIT]; // RL2
  assign rtc_osc_fail_priority     = prio_reg[RTC_BIT]; // RL3
  assign port_match_priority       = prio_reg[MATCH_BIT]; // RL4
  assign supply_warning_priority   = prio_reg[SUPPLY_BIT]; // RL5

  // Both channels are identical apart from which fields they take.
  irq_chan_if chan [2] ();
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      assign chan[g].pins      = port0_pins; // RL10
      assign chan[g].pin_sel   = chan_sel(cfg_reg, 1'(g)); // RL9
      assign chan[g].polarity  = chan_pol(cfg_reg, 1'(g)); // RL6 RL8
      assign chan[g].edge_mode = trig_reg[g]; // RL6 RL7
      assign chan[g].vec_clear = vector_ack[g]; // RL13
      assign chan[g].sw_write  = wr_tctl;
      assign chan[g].sw_value  = g ? wbyte[SECOND_PEND_BIT] : wbyte[FIRST_PEND_BIT];
      assign pend[g]           = chan[g].pending;
      assign rise[g]           = chan[g].rise;
      irq_detect u_det (
        .clk (clk),
        .rst (rst),
        .ch  (chan[g])
      );
    end
  endgenerate

  assign first_input_pending  = pend[0]; // RL12
  assign second_input_pending = pend[1]; // RL12

  // A skipped pin belongs to the interrupt inputs alone, so the peripheral
  // loses its drive there; the inputs themselves never touch pin drive.
  assign pin_out = periph_pin_out & ~crossbar_skip; // RL11
  assign pin_oe  = periph_pin_oe & ~crossbar_skip; // RL11 RL10

  // Level sources must keep and then drop the request on their own; the
  // flag tracks the pin, so a source that holds on re-requests.

  // Helper views for the checks below.
  wire [2:0] sel0_w = cfg_reg[FIRST_SEL_LSB +: 3];
  wire [2:0] sel1_w = cfg_reg[SECOND_SEL_LSB +: 3];
  wire       pin0_w = port0_pins[sel0_w];
  wire       pin1_w = port0_pins[sel1_w];
  wire       pol0_w = cfg_reg[FIRST_POL_BIT];
  wire       pol1_w = cfg_reg[SECOND_POL_BIT];
  wire       prio_rd = wb_ack_o & ~wb_we_i & hit_prio;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_prio_upper_zero: assert property ( // RL1
    prio_rd |-> wb_dat_o[7:4] == 4'h0)
    else $error("unused priority bits read nonzero");

  a_prio_radio_bit: assert property ( // RL2
    wr_prio |=> radio_serial_irq_priority == $past(wb_dat_i[3]))
    else $error("radio serial priority not taken from write");

  a_prio_rtc_bit: assert property ( // RL3
    wr_prio ##1 !wr_prio[*2] |-> rtc_osc_fail_priority == $past(wb_dat_i[2], 2))
    else $error("oscillator fail priority not held after write");

  a_prio_match_bit: assert property ( // RL4
    wr_prio |=> port_match_priority == $past(wb_dat_i[1]))
    else $error("port match priority not taken from write");

  a_prio_supply_bit: assert property ( // RL5
    !wr_prio |=> $stable(supply_warning_priority))
    else $error("supply warning priority changed without a write");

  a_prio_readback: assert property ( // RL2
    prio_rd |-> wb_dat_o[3:0] == {radio_serial_irq_priority, rtc_osc_fail_priority,
                                  port_match_priority, supply_warning_priority})
    else $error("priority read disagrees with priority outputs");

  // The sample flop restarts at its reset value, so the first edge after
  // reset does not reflect the pin yet.
  a_level_follow0: assert property ( // RL14
    !$past(rst) && !trig_reg[0] && $stable(cfg_reg) && $stable(trig_reg)
      |-> first_input_pending == ($past(pin0_w) == pol0_w))
    else $error("first input level flag does not follow its pin");

  a_level_follow1: assert property ( // RL14
    !$past(rst) && !trig_reg[1] && $stable(cfg_reg) && $stable(trig_reg)
      |-> second_input_pending == ($past(pin1_w) == pol1_w))
    else $error("second input level flag does not follow its pin");

  a_edge_sets0: assert property ( // RL13
    trig_reg[0] && $stable(cfg_reg) && $past(cfg_reg) == $past(cfg_reg, 2)
      && $past(pin0_w, 2) != pol0_w && $past(pin0_w) == pol0_w
      |=> first_input_pending)
    else $error("first input edge did not set its flag");

  a_edge_steady1: assert property ( // RL18
    trig_reg[1] && !second_input_pending && !rise[1] && !wr_tctl
      |=> !second_input_pending)
    else $error("second input flag set without an edge");

  a_vector_clear0: assert property ( // RL13
    trig_reg[0] && $stable(trig_reg) && vector_ack[0] && !rise[0] && !wr_tctl
      |=> !first_input_pending)
    else $error("vectoring did not clear first input flag");

  a_set_wins0: assert property ( // RL13
    trig_reg[0] && $stable(trig_reg) && rise[0] && vector_ack[0]
      |=> first_input_pending)
    else $error("edge lost against a simultaneous clear");

  a_skip_blocks: assert property ( // RL11
    (pin_oe & crossbar_skip) == 8'h00 && (pin_out & crossbar_skip) == 8'h00)
    else $error("skipped pin still driven by a peripheral");

  a_cfg_reset: assert property ( // RL17
    $past(rst) |-> cfg_reg == CFG_RESET)
    else $error("pin configuration wrong after reset");

  a_mode_select: assert property ( // RL7
    wr_tctl |=> trig_reg == {$past(wb_dat_i[SECOND_TRIG_BIT]), $past(wb_dat_i[FIRST_TRIG_BIT])})
    else $error("trigger type bits not taken from write");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_edge_pend: cover property (trig_reg[0] && rise[0] ##1 first_input_pending);
  c_level_pend: cover property (!trig_reg[1] && second_input_pending);
  c_prio_write: cover property (wr_prio && wb_dat_i[3:0] == 4'hf);
  c_vector_clear: cover property (first_input_pending && vector_ack[0] && trig_reg[0]);
endmodule : ext_int_config

// ---- hdl/irq_detect.sv ----
/*
 * One external interrupt channel: pin selection, polarity, edge or level flag.
 * Assumes port pins are synchronous to clk and the clear request is a pulse.
 */
module irq_detect
  import eic_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst,
  irq_chan_if.detect  ch
);
  logic sample_reg;
  logic prev_reg;
  logic edge_reg;
  logic edge_next;
  wire  clear_now = ch.vec_clear | (ch.sw_write & ~ch.sw_value);
  wire  set_now   = ch.sw_write & ch.sw_value;

  // The pin is only read here, so its crossbar owner is never disturbed.
  assign ch.active = ~(sample_reg ^ ch.polarity); // RL8
  assign ch.rise   = ch.active & ~prev_reg; // RL18

  // A new edge wins over a clear in the same cycle. The flag is emptied in
  // level mode so that a later switch to edge mode starts clean.
  assign edge_next = ch.edge_mode & (ch.rise | set_now | (edge_reg & ~clear_now)); // RL13

  // Level mode shows the input itself; edge mode shows the latched flag.
  assign ch.pending = ch.edge_mode ? edge_reg : ch.active; // RL7 RL14

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_reg <= 1'b1;
      prev_reg   <= 1'b1;
      edge_reg   <= 1'b0;
    end else begin
      sample_reg <= ch.pins[ch.pin_sel]; // RL9 RL10
      prev_reg   <= ch.active; // RL18
      edge_reg   <= edge_next;
    end
  end
endmodule : irq_detect

// ---- hdl/wb_front.sv ----
/*
 * Classic Wishbone slave handshake: one wait cycle, then a one-cycle ack.
 * Assumes the master holds its request until ack and then drops cyc and stb.
 */
module wb_front
  import eic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic        sel0,
  input  wire logic [7:0]  rd_word,
  output logic             ack,
  output logic [31:0]      dat_o,
  output logic             wr_commit
);
  bus_state_t state_reg;
  bus_state_t state_next;
  wire        req = cyc & stb;

  assign state_next = (state_reg == BUS_IDLE && req) ? BUS_ANSWER : BUS_IDLE;
  assign ack        = (state_reg == BUS_ANSWER);
  // Writes land on the edge that samples ack, never earlier.
  assign wr_commit  = ack & req & we & sel0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= BUS_IDLE;
      dat_o     <= 32'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == BUS_IDLE && req) begin
        dat_o <= {24'h0, rd_word};
      end
    end
  end
endmodule : wb_front

// ---- include/eic_pkg.sv ----
/*
 * Shared constants for the external interrupt configuration block: register
 * indexes and byte addresses, field positions, reset values and bus states.
 * Assumes a Wishbone bus with byte addressing and one 32-bit word per register.
 */
package eic_pkg;
  localparam int unsigned ADR_W = 12;
  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] CFG_IDX  = 8'he4;
  localparam logic [7:0] PRIO_IDX = 8'hf7;
  localparam logic [7:0] TCTL_IDX = 8'h40;
  localparam logic [ADR_W-1:0] CFG_ADDR  = {2'h0, CFG_IDX, 2'h0};
  localparam logic [ADR_W-1:0] PRIO_ADDR = {2'h0, PRIO_IDX, 2'h0};
  localparam logic [ADR_W-1:0] TCTL_ADDR = {2'h0, TCTL_IDX, 2'h0};
  localparam logic [7:0] CFG_RESET  = 8'h01;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [3:0] PRIO_UNUSED = 4'h0;
  // Pin configuration fields.
  localparam int unsigned FIRST_SEL_LSB  = 0;
  localparam int unsigned FIRST_POL_BIT  = 3;
  localparam int unsigned SECOND_SEL_LSB = 4;
  localparam int unsigned SECOND_POL_BIT = 7;
  // Timer control fields held here.
  localparam int unsigned FIRST_TRIG_BIT  = 0;
  localparam int unsigned FIRST_PEND_BIT  = 1;
  localparam int unsigned SECOND_TRIG_BIT = 2;
  localparam int unsigned SECOND_PEND_BIT = 3;
  // Second extended priority fields.
  localparam int unsigned SUPPLY_BIT = 0;
  localparam int unsigned MATCH_BIT  = 1;
  localparam int unsigned RTC_BIT    = 2;
  localparam int unsigned RADIO_BIT  = 3;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

  function automatic logic [2:0] chan_sel(input logic [7:0] cfg, input logic ch);
    return ch ? cfg[SECOND_SEL_LSB +: 3] : cfg[FIRST_SEL_LSB +: 3];
  endfunction : chan_sel

  function automatic logic chan_pol(input logic [7:0] cfg, input logic ch);
    return ch ? cfg[SECOND_POL_BIT] : cfg[FIRST_POL_BIT];
  endfunction : chan_pol
endpackage : eic_pkg

// ---- include/irq_chan_if.sv ----
/*
 * Signals between the register logic and one external interrupt channel.
 * Assumes the register side drives configuration and the channel drives flags.
 */
interface irq_chan_if;
  logic [7:0] pins;
  logic [2:0] pin_sel;
  logic       polarity;
  logic       edge_mode;
  logic       vec_clear;
  logic       sw_write;
  logic       sw_value;
  logic       active;
  logic       rise;
  logic       pending;
  modport detect (input pins, pin_sel, polarity, edge_mode, vec_clear, sw_write,
                  sw_value, output active, rise, pending);
  modport ctrl (output pins, pin_sel, polarity, edge_mode, vec_clear, sw_write,
                sw_value, input active, rise, pending);
endinterface : irq_chan_if

// ---- tb/external_interrupt_config_test.sv ----
/*
 * Self-checking bench: Wishbone register access, priority bits, crossbar
 * gating and every polarity and trigger mode of both interrupt inputs.
 * Assumes the design answers each bus request with one ack pulse.
 */
module external_interrupt_config_test
  import eic_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk;
  logic             rst;
  logic             cyc;
  logic             stb;
  logic             we;
  logic [3:0]       sel;
  logic [ADR_W-1:0] adr;
  logic [31:0]      wdat;
  logic [31:0]      rdat;
  logic             ack;
  logic [7:0]       pins;
  logic [1:0]       vack;
  logic [7:0]       skip;
  logic [7:0]       pout;
  logic [7:0]       poe;
  logic [7:0]       pin_out;
  logic [7:0]       pin_oe;
  logic             pend0;
  logic             pend1;
  logic [3:0]       prio;
  logic             fire;
  logic [2:0]       src_sel;
  logic             src_hi;
  logic [31:0]      q;
  logic [7:0]       cfg;
  logic [2:0]       p;
  logic             ch;
  logic             pol;
  logic             trig;
  int               fails;
  int               comparisons;

  ext_int_config DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port0_pins(pins), .vector_ack(vack), .crossbar_skip(skip), .periph_pin_out(pout),
    .periph_pin_oe(poe), .pin_out(pin_out), .pin_oe(pin_oe), .first_input_pending(pend0),
    .second_input_pending(pend1), .radio_serial_irq_priority(prio[3]),
    .rtc_osc_fail_priority(prio[2]), .port_match_priority(prio[1]),
    .supply_warning_priority(prio[0]));

  irq_source source (.clk(clk), .rst(rst), .fire(fire), .pin_sel(src_sel),
    .active_high(src_hi), .seen(ch ? pend1 : pend0), .pins(pins));

  always #5 clk = ~clk;

  task automatic conclude();
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  // One classic cycle; read data is taken at the same edge that sees ack.
  task automatic wbx(input logic w, input logic [ADR_W-1:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask : wbx

  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] exp);
    wbx(1'b0, a, 4'hf, 32'h0);
    chk($sformatf("register %h", a), exp, q);
  endtask : rd

  function automatic logic pend(input logic c);
    return c ? pend1 : pend0;
  endfunction : pend

  task automatic wait_pend(input logic c, input logic v);
    int n;
    n = 0;
    while (pend(c) !== v && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("pending", {31'h0, v}, {31'h0, pend(c)});
    if (pend(c) !== v) begin
      conclude();
    end
  endtask : wait_pend

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, sel, adr, wdat, vack, fire, src_sel, src_hi, ch} = '0;
    skip = 8'h00;
    pout = 8'h00;
    poe = 8'h00;
    fails = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(CFG_ADDR, 32'h01);
    rd(PRIO_ADDR, 32'h00);
    rd(TCTL_ADDR, 32'h00);
    chk("pending pair", 32'h0, {30'h0, pend1, pend0});
    for (int i = 0; i < 4; i++) begin
      wbx(1'b1, PRIO_ADDR, 4'hf, 32'hf0 | (32'h1 << i));
      rd(PRIO_ADDR, 32'h1 << i);
      chk("priority outputs", 32'h1 << i, {28'h0, prio});
    end
    wbx(1'b1, 12'h200, 4'hf, 32'hff);
    rd(12'h200, 32'h0);
    wbx(1'b1, CFG_ADDR, 4'he, 32'h77);
    rd(CFG_ADDR, 32'h01);
    skip <= 8'h0f;
    pout <= 8'ha5;
    poe <= 8'hff;
    @(posedge clk);
    @(posedge clk);
    chk("pin drive", 32'ha0, {24'h0, pin_out});
    chk("pin enable", 32'hf0, {24'h0, pin_oe});
    // Each pass puts the other input on a different pin at its idle level.
    for (int k = 0; k < 8; k++) begin
      ch = k[2];
      pol = k[1];
      trig = k[0];
      p = k[2:0];
      cfg = ch ? {pol, p, pol, ~p} : {pol, ~p, pol, p};
      src_hi <= pol;
      src_sel <= p;
      wbx(1'b1, CFG_ADDR, 4'h1, {24'h0, cfg});
      rd(CFG_ADDR, {24'h0, cfg});
      repeat (4) @(posedge clk);
      // A polarity change can leave a stale edge flag, so both are cleared here.
      wbx(1'b1, TCTL_ADDR, 4'h1, {28'h0, 1'b0, trig, 1'b0, trig});
      // The clearing write lands at the ack edge, so look one edge later.
      @(posedge clk);
      chk("idle pending", 32'h0, {30'h0, pend1, pend0});
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      wait_pend(ch, 1'b1);
      chk("other pending", 32'h0, {31'h0, pend(~ch)});
      if (trig) begin
        repeat (3) @(posedge clk);
        chk("edge flag", 32'h1, {31'h0, pend(ch)});
        rd(TCTL_ADDR, 32'h05 | (ch ? 32'h08 : 32'h02));
        @(posedge clk);
        vack <= ch ? 2'b10 : 2'b01;
        @(posedge clk);
        vack <= 2'b00;
        wait_pend(ch, 1'b0);
      end else begin
        wait_pend(ch, 1'b0);
      end
    end
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(CFG_ADDR, 32'h01);
    rd(PRIO_ADDR, 32'h00);
    conclude();
  end
endmodule : external_interrupt_config_test

// ---- tb/irq_source.sv ----
/*
 * Model of the external circuit that raises one interrupt request on port 0.
 * Assumes the bench names the pin and its active level and feeds back the flag.
 */
module irq_source
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fire,
  input  wire logic [2:0] pin_sel,
  input  wire logic       active_high,
  input  wire logic       seen,
  output logic [7:0]      pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic held_reg;
  // The request stays active until the flag shows it was recognised, then drops
  // at once so that it never outlives the service routine.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_reg <= 1'b0;
    end else if (fire) begin
      held_reg <= 1'b1;
    end else if (seen) begin
      held_reg <= 1'b0;
    end
  end
  assign pins = {8{~active_high}} ^ (held_reg ? 8'h01 << pin_sel : 8'h00);
endmodule : irq_source
